// file: core/mma_pkg.sv
// package for the management-bus indirect access engine
package mma_pkg;
    localparam logic [15:0] ADDR_COMMAND = 16'hf408;
    localparam logic [15:0] ADDR_READ_RESULT = 16'hf409;
    localparam logic [15:0] ADDR_WRITE_PAYLOAD = 16'hf40a;
    localparam logic [15:0] ADDR_CLOCK_CFG = 16'hf40c;
    localparam logic [15:0] RESET_COMMAND = 16'h0000;
    localparam logic [15:0] RESET_READ_RESULT = 16'h0000;
    localparam logic [15:0] RESET_WRITE_PAYLOAD = 16'h0000;
    localparam logic [15:0] RESET_CLOCK_CFG = 16'h0109;
    localparam int PENDING_BIT = 12;
    localparam int OPCODE_HI = 11;
    localparam int OPCODE_LO = 10;
    localparam int PORT_HI = 9;
    localparam int PORT_LO = 5;
    localparam int REG_HI = 4;
    localparam int REG_LO = 0;
    localparam int CLOCK_EN_BIT = 8;
    localparam int FREQ_HI = 7;
    localparam int FREQ_LO = 0;
    localparam logic [15:0] CLOCK_CFG_MASK = 16'h01ff;
    localparam logic [1:0] OPCODE_WRITE = 2'b01;
    localparam logic [1:0] OPCODE_READ = 2'b10;
    localparam logic [1:0] START_CODE = 2'b01;
    localparam logic [1:0] TURNAROUND_WR = 2'b10;
    localparam logic [5:0] PREAMBLE_BITS = 6'h20;
    localparam logic [5:0] FRAME_BITS = 6'h20;
    localparam logic [5:0] TA_FIRST_BIT = 6'h0e;
    localparam logic [5:0] DATA_FIRST_BIT = 6'h10;
    localparam logic [3:0] PRESCALE_LAST = 4'h4;
    localparam int SYS_CLOCK_MHZ = 125;
    localparam int CLOCK_PERIOD_NS = 1000 / SYS_CLOCK_MHZ;

    typedef enum logic [1:0] {
        MMA_IDLE,
        MMA_PREAMBLE,
        MMA_FRAME
    } mma_state_t;

    typedef struct packed {
        logic [15:0] addr;
        logic [15:0] wdata;
        logic write;
        logic read;
    } mma_bus_req_t;

    typedef struct packed {
        logic mdc;
        logic mdio_out;
        logic mdio_oe;
    } mma_link_out_t;
endpackage

// file: core/mma_engine.sv
// management-bus master engine with command, result, payload and clock registers
//
// Design decision made here: the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
// Contract
// - each command write while idle starts one frame
// - one serial port serves inside and outside
// - command write sets pending bit twelve
// - pending clears when a new command fits
// - pending reads one busy, zero idle
// - written pending value is ignored
// - opcode copied into frame; 01 write, 10 read
// - port address copied into frame
// - register address copied into frame
// - returned word lands in result register
// - link clock is sysclk/5/((freq+1)*2)
// - clock drive off releases clock and data
module mma_engine (
    input wire logic clock,
    input wire logic reset_n,
    input wire mma_pkg::mma_bus_req_t bus_req,
    output logic [15:0] bus_rdata,
    output mma_pkg::mma_link_out_t link_out,
    input wire logic mdio_in
);
    import mma_pkg::*;

    typedef struct packed {
        mma_state_t state;
        logic [15:0] command;
        logic [15:0] read_result;
        logic [15:0] write_payload;
        logic [15:0] clock_cfg;
        logic [15:0] rdata;
        logic [31:0] shift;
        logic [15:0] capture;
        logic [5:0] bit_count;
        logic [3:0] prescale;
        logic [7:0] half_count;
        logic mdc;
        logic mdc_pin;
        logic mdio_out;
        logic mdio_oe;
    } mma_regs_t;

    mma_regs_t r;
    mma_regs_t next_r;

    function automatic logic [15:0] read_mux(input mma_regs_t s, input logic [15:0] a);
        logic [15:0] v;
        v = 16'h0000;
        if (a == ADDR_COMMAND) begin
            v = s.command;
        end else if (a == ADDR_READ_RESULT) begin
            v = s.read_result;
        end else if (a == ADDR_WRITE_PAYLOAD) begin
            v = s.write_payload;
        end else if (a == ADDR_CLOCK_CFG) begin
            v = s.clock_cfg;
        end
        return v;
    endfunction

    logic clock_en;
    logic half_tick;
    logic rising;
    logic falling;
    logic is_read;

    always_comb begin
        next_r = r;
        clock_en = r.clock_cfg[CLOCK_EN_BIT];
        // two-stage divider: fixed by five, then by (freq+1) per half period
        half_tick = (r.prescale == PRESCALE_LAST)
            && (r.half_count == r.clock_cfg[FREQ_HI:FREQ_LO]);
        rising = half_tick && !r.mdc;
        falling = half_tick && r.mdc;
        is_read = (r.command[OPCODE_HI:OPCODE_LO] == OPCODE_READ);

        if (r.prescale == PRESCALE_LAST) begin
            next_r.prescale = 4'h0;
            if (half_tick) begin
                next_r.half_count = 8'h00;
            end else begin
                next_r.half_count = r.half_count + 8'h01;
            end
        end else begin
            next_r.prescale = r.prescale + 4'h1;
        end

        // mdc only toggles while a frame runs; it idles low
        if (r.state == MMA_IDLE) begin
            next_r.mdc = 1'b0;
        end else if (half_tick) begin
            next_r.mdc = !r.mdc;
        end

        next_r.rdata = 16'h0000;
        if (bus_req.read) begin
            next_r.rdata = read_mux(r, bus_req.addr);
        end

        if (bus_req.write) begin
            if (bus_req.addr == ADDR_WRITE_PAYLOAD) begin
                next_r.write_payload = bus_req.wdata;
            end else if (bus_req.addr == ADDR_CLOCK_CFG) begin
                next_r.clock_cfg = bus_req.wdata & CLOCK_CFG_MASK;
            end
        end

        case (r.state)
            MMA_IDLE: begin
                next_r.mdio_oe = 1'b0;
                next_r.mdio_out = 1'b1;
                // a command arriving while busy is dropped, it never queues
                if (bus_req.write && bus_req.addr == ADDR_COMMAND) begin
                    next_r.command = {3'b000, 1'b1, bus_req.wdata[OPCODE_HI:0]};
                    next_r.shift = {START_CODE, bus_req.wdata[OPCODE_HI:OPCODE_LO],
                        bus_req.wdata[PORT_HI:PORT_LO], bus_req.wdata[REG_HI:REG_LO],
                        TURNAROUND_WR, r.write_payload};
                    next_r.bit_count = 6'h00;
                    next_r.state = MMA_PREAMBLE;
                    next_r.prescale = 4'h0;
                    next_r.half_count = 8'h00;
                end
            end
            MMA_PREAMBLE: begin
                next_r.mdio_oe = clock_en;
                if (falling) begin
                    next_r.mdio_out = 1'b1;
                    if (r.bit_count == PREAMBLE_BITS - 6'h01) begin
                        next_r.bit_count = 6'h00;
                        next_r.state = MMA_FRAME;
                        next_r.mdio_out = r.shift[31];
                        next_r.shift = {r.shift[30:0], 1'b0};
                    end else begin
                        next_r.bit_count = r.bit_count + 6'h01;
                    end
                end
            end
            MMA_FRAME: begin
                // release the line from turnaround on for reads
                next_r.mdio_oe = clock_en && !(is_read && r.bit_count >= TA_FIRST_BIT);
                if (rising && is_read && r.bit_count >= DATA_FIRST_BIT) begin
                    next_r.capture = {r.capture[14:0], mdio_in};
                end
                if (falling) begin
                    if (r.bit_count == FRAME_BITS - 6'h01) begin
                        next_r.state = MMA_IDLE;
                        next_r.command[PENDING_BIT] = 1'b0;
                        next_r.mdio_oe = 1'b0;
                        if (is_read) begin
                            next_r.read_result = r.capture;
                        end
                    end else begin
                        next_r.bit_count = r.bit_count + 6'h01;
                        next_r.mdio_out = r.shift[31];
                        next_r.shift = {r.shift[30:0], 1'b0};
                    end
                end
            end
            default: begin
                next_r.state = MMA_IDLE;
            end
        endcase
        // pin copy is gated before the flop so the output leaves a register
        next_r.mdc_pin = next_r.mdc && next_r.clock_cfg[CLOCK_EN_BIT];
    end

    always_ff @(posedge clock) begin
        if (!reset_n) begin
            r <= '0;
            r.state <= MMA_IDLE;
            r.command <= RESET_COMMAND;
            r.read_result <= RESET_READ_RESULT;
            r.write_payload <= RESET_WRITE_PAYLOAD;
            r.clock_cfg <= RESET_CLOCK_CFG;
            r.mdio_out <= 1'b1;
        end else begin
            r <= next_r;
        end
    end

    assign bus_rdata = r.rdata;
    // drivers are gated by the clock-drive enable; the frame still runs internally
    assign link_out.mdc = r.mdc_pin;
    assign link_out.mdio_out = r.mdio_out;
    assign link_out.mdio_oe = r.mdio_oe;
endmodule // mma_engine
`default_nettype wire

// file: tb/mma_engine_sva.sv
// checker on the engine ports
`timescale 1ns/1ps
`default_nettype none
module mma_engine_sva (
    input wire logic clock,
    input wire logic reset_n,
    input wire mma_pkg::mma_bus_req_t bus_req,
    input wire logic [15:0] bus_rdata,
    input wire mma_pkg::mma_link_out_t link_out
);
    import mma_pkg::*;
    logic cw, rc, cf, m, oe, d;
    assign cw = bus_req.write && bus_req.addr == ADDR_COMMAND;
    assign rc = bus_req.read && bus_req.addr == ADDR_COMMAND;
    assign cf = bus_req.read && bus_req.addr == ADDR_CLOCK_CFG;
    assign m = link_out.mdc;
    assign oe = link_out.mdio_oe;
    assign d = link_out.mdio_out;
    default clocking @(posedge clock); endclocking
    default disable iff (!reset_n);
    a_rdata_quiet: assert property (!$past(bus_req.read) |-> bus_rdata == 16'h0000)
        else $error("stray read data");
    a_pending_set: assert property ($past(cw, 3) && $past(rc) |-> bus_rdata[12])
        else $error("pending not set");
    a_cfg_upper: assert property ($past(cf) |-> bus_rdata[15:9] == 7'h00)
        else $error("cfg upper bits");
    a_start_cause: assert property ($rose(oe) |-> $past(cw) || $past(cw, 2))
        else $error("frame without command");
    a_preamble_ones: assert property ($rose(oe) |-> (oe && d)[*8])
        else $error("preamble broken");
    a_mdc_high: assert property ($rose(m) |-> m[*5])
        else $error("clock high too short");
    a_mdc_low: assert property ($fell(m) |-> (!m)[*5])
        else $error("clock low too short");
    a_data_on_fall: assert property ($changed(d) && oe && $past(oe)
        |-> !m && $past(m))
        else $error("data moved off falling clock");
endmodule // mma_engine_sva
bind mma_engine mma_engine_sva i_mma_engine_sva (.clock(clock), .reset_n(reset_n),
    .bus_req(bus_req), .bus_rdata(bus_rdata), .link_out(link_out));
`default_nettype wire

// file: tb/mma_phy_model.sv
// management device model; the data line has a pull-up
`timescale 1ns/1ps
`default_nettype none
module mma_phy_model (
    input wire logic clock,
    input wire mma_pkg::mma_link_out_t link_out,
    input wire logic [15:0] reply,
    output logic mdio_in,
    output logic [63:0] seen,
    output logic [6:0] cnt
);
    import mma_pkg::*;
    logic mdc_q = 0, oe_q = 0, rd = 0, drv;
    // drive turnaround low then data, one cycle after each rising clock
    assign drv = rd && cnt >= 7'd47 && cnt <= 7'd63;
    assign mdio_in = oe_q && link_out.mdio_oe ? link_out.mdio_out
        : (drv ? cnt != 7'd47 && reply[7'd63 - cnt] : 1'b1);
    always @(posedge clock) begin
        mdc_q <= link_out.mdc;
        oe_q <= link_out.mdio_oe;
        if (link_out.mdio_oe && !oe_q) begin
            cnt <= 7'd0;
        end else if (link_out.mdc && !mdc_q) begin
            cnt <= cnt + 7'd1;
            seen <= {seen[62:0], mdio_in};
        end
        if (cnt == 7'd36) rd <= seen[1:0] == OPCODE_READ;
    end
endmodule // mma_phy_model
`default_nettype wire

// file: tb/mma_engine_tb.sv
// testbench for the management engine
`timescale 1ns/1ps
`default_nettype none
module mma_engine_tb;
    import mma_pkg::*;
    logic clock = 0, reset_n = 0, mdio_in, mdc_q = 0;
    mma_bus_req_t bus_req = '0;
    logic [15:0] rd, reply = 16'hc3a5;
    mma_link_out_t link_out;
    logic [63:0] seen;
    logic [6:0] cnt;
    int err_total = 0, checked = 0, cyc = 0, n, t0, per, last_rise, last_act;
    logic [15:0] ra [5] = '{ADDR_COMMAND, ADDR_READ_RESULT, ADDR_WRITE_PAYLOAD,
        ADDR_CLOCK_CFG, 16'hf40b};
    logic [15:0] re [5] = '{'0, '0, '0, RESET_CLOCK_CFG, '0};
    logic [15:0] rd_w;
    always #4 clock = ~clock;
    mma_engine i_mma_engine (.clock(clock), .reset_n(reset_n), .bus_req(bus_req),
        .bus_rdata(rd_w), .link_out(link_out), .mdio_in(mdio_in));
    mma_phy_model i_mma_phy_model (.clock(clock), .link_out(link_out), .reply(reply),
        .mdio_in(mdio_in), .seen(seen), .cnt(cnt));
    task results;
        $display("checks %0d errors %0d", checked, err_total);
        if (err_total == 0 && checked > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    task cmp(input logic [63:0] g, e);
        checked++;
        if (g !== e) begin
            err_total++;
            $display("unexpected at %0t: got %h want %h", $time, g, e);
        end
    endtask
    task wr(input logic [15:0] a, dt);
        bus_req <= '{a, dt, 1'b1, 1'b0};
        @(posedge clock);
        bus_req.write <= 1'b0;
        @(posedge clock);
    endtask
    task rdreg(input logic [15:0] a);
        bus_req <= '{a, 16'h0000, 1'b0, 1'b1};
        @(posedge clock);
        bus_req.read <= 1'b0;
        #1 rd = rd_w;
        @(posedge clock);
    endtask
    task idle;
        n = 0;
        do begin
            rdreg(ADDR_COMMAND);
            n++;
        end while (rd[PENDING_BIT] !== 1'b0 && n < 1000);
    endtask
    always @(posedge clock) begin
        cyc <= cyc + 1;
        mdc_q <= link_out.mdc;
        if (link_out.mdc && !mdc_q) begin
            per <= cyc - last_rise;
            last_rise <= cyc;
        end
        if (link_out.mdc || link_out.mdio_oe) last_act <= cyc;
        if (cyc == 8000) begin
            err_total++;
            results;
        end
    end
    initial begin
        repeat (6) @(posedge clock);
        reset_n <= 1'b1;
        @(posedge clock);
        wr(ADDR_READ_RESULT, 16'hffff);
        foreach (ra[i]) begin
            rdreg(ra[i]);
            cmp(rd, re[i]);
        end
        wr(ADDR_CLOCK_CFG, 16'h0100);
        wr(ADDR_WRITE_PAYLOAD, 16'h5a3c);
        wr(ADDR_COMMAND, 16'h066a);
        wr(ADDR_COMMAND, 16'h1bff);
        rdreg(ADDR_COMMAND);
        cmp(rd, 16'h166a);
        idle;
        cmp(rd[PENDING_BIT], 0);
        cmp(seen, {32'hffff_ffff, 16'h59aa, 16'h5a3c});
        cmp(cnt, 64);
        cmp(per, 10);
        wr(ADDR_CLOCK_CFG, 16'h0101);
        wr(ADDR_COMMAND, 16'h08bf);
        idle;
        cmp(rd[PENDING_BIT], 0);
        rdreg(ADDR_READ_RESULT);
        cmp(rd, reply);
        cmp(seen[31:18], 14'h18bf);
        cmp(per, 20);
        wr(ADDR_CLOCK_CFG, 16'h0000);
        wr(ADDR_COMMAND, 16'h08bf);
        t0 = cyc;
        idle;
        cmp(rd[PENDING_BIT], 0);
        cmp(last_act < t0, 1);
        results;
    end
endmodule // mma_engine_tb
`default_nettype wire
